// ### pkg/cfr_pkg.sv
package cfr_pkg;
    // select codes of the feature words
    localparam int SEL_W = 3;
    localparam logic [2:0] SEL_WORD0 = 3'h0;
    localparam logic [2:0] SEL_WORD1 = 3'h1;
    localparam logic [2:0] SEL_WORD3 = 3'h3;

    // writable cache attribute fields
    localparam int ATTR_W = 3;
    localparam int ATTR_NUM = 3;
    localparam int ATTR_HIGH = 0;
    localparam int ATTR_USER = 1;
    localparam int ATTR_SEG0 = 2;
    localparam logic [2:0] ATTR_RESET = 3'h2;

    // word0 layout
    localparam int W0_NEXT_BIT = 31;
    localparam int W0_HIGH_LSB = 28;
    localparam int W0_USER_LSB = 25;
    localparam int W0_CUSTOM_BIT = 22;
    localparam int W0_SIMPLE_BE_BIT = 21;
    localparam int W0_MULDIV_BIT = 20;
    localparam int W0_DUAL_SRAM_BIT = 16;
    localparam int W0_BYTE_ORDER_BIT = 15;
    localparam int W0_ARCH_LSB = 13;
    localparam int W0_REL_LSB = 10;
    localparam int W0_MAP_LSB = 7;
    localparam int W0_SEG0_LSB = 0;
    localparam logic [31:0] W0_RSVD_MASK = 32'h018e_0078;
    localparam logic W0_NEXT_VAL = 1'h1;
    localparam logic W0_CUSTOM_VAL = 1'h0;
    localparam logic W0_SIMPLE_BE_VAL = 1'h1;
    localparam logic W0_MULDIV_VAL = 1'h0;
    localparam logic W0_DUAL_SRAM_VAL = 1'h1;
    localparam logic W0_BYTE_ORDER_VAL = 1'h0;
    localparam logic [1:0] W0_ARCH_VAL = 2'h0;
    localparam logic [2:0] W0_REL_VAL = 3'h1;
    localparam logic [2:0] W0_MAP_VAL = 3'h3;

    // word1 layout
    localparam int W1_NEXT_BIT = 31;
    localparam int W1_PERF_BIT = 4;
    localparam int W1_WATCH_BIT = 3;
    localparam int W1_COMPRESSED_BIT = 2;
    localparam int W1_DEBUG_BIT = 1;
    localparam int W1_FLOAT_BIT = 0;
    localparam logic W1_NEXT_VAL = 1'h1;
    localparam logic W1_PERF_VAL = 1'h1;
    localparam logic W1_WATCH_VAL = 1'h0;
    localparam logic W1_COMPRESSED_VAL = 1'h0;
    localparam logic W1_DEBUG_VAL = 1'h1;
    localparam logic W1_FLOAT_VAL = 1'h0;

    // word3 layout
    localparam int W3_RSVD_BIT = 31;
    localparam int W3_PRIO_LSB = 21;
    localparam int W3_CISA_REV_LSB = 18;
    localparam int W3_MCU_BIT = 17;
    localparam int W3_EXC_ISA_BIT = 16;
    localparam int W3_ISA_LSB = 14;
    localparam int W3_USER_LOCAL_REG_FLAG_BIT = 13;
    localparam int W3_RXI_BIT = 12;
    localparam int W3_FLOW_BIT = 8;
    localparam int W3_EXT_VECTOR_CTRL_FLAG_BIT = 6;
    localparam int W3_VECTORED_IRQ_FLAG_BIT = 5;
    localparam int W3_SPAGE_BIT = 4;
    localparam int W3_DEVICE_MAP_FLAG_BIT = 3;
    localparam int W3_TRACE_BIT = 0;
    localparam logic W3_RSVD_VAL = 1'h0;
    localparam logic [1:0] W3_PRIO_VAL = 2'h1;
    localparam logic [2:0] W3_CISA_REV_VAL = 3'h0;
    localparam logic W3_MCU_VAL = 1'h1;
    localparam logic W3_EXC_ISA_VAL = 1'h1;
    localparam logic [1:0] W3_ISA_VAL = 2'h1;
    localparam logic W3_USER_LOCAL_REG_FLAG_VAL = 1'h1;
    localparam logic W3_RXI_VAL = 1'h1;
    localparam logic W3_FLOW_VAL = 1'h0;
    localparam logic W3_EXT_VECTOR_CTRL_FLAG_VAL = 1'h1;
    localparam logic W3_VECTORED_IRQ_FLAG_VAL = 1'h1;
    localparam logic W3_SPAGE_VAL = 1'h0;
    localparam logic W3_DEVICE_MAP_FLAG_VAL = 1'h1;
    localparam logic W3_TRACE_VAL = 1'h0;
endpackage

// ### pkg/cfr_attr_if.sv
`timescale 1ns/100ps
// carries cache attribute updates and current values between modules
interface cfr_attr_if;
    logic wr_en;
    logic [cfr_pkg::ATTR_NUM-1:0][cfr_pkg::ATTR_W-1:0] wr_val;
    logic [cfr_pkg::ATTR_NUM-1:0][cfr_pkg::ATTR_W-1:0] attr;

    modport ctrl (output wr_en, output wr_val, input attr);
    modport store (input wr_en, input wr_val, output attr);
endinterface

// ### verilog/cfr_attr_store.sv
`timescale 1ns/100ps
// holds the three writable cacheability fields of word0
module cfr_attr_store (
    input wire logic clk_i,
    input wire logic rst_n_i,
    cfr_attr_if.store attr_if
);
    genvar gi;

    // one field register per attribute, all loaded together
    generate
        for (gi = 0; gi < cfr_pkg::ATTR_NUM; gi++) begin : g_attr
            logic [cfr_pkg::ATTR_W-1:0] attr_q;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    attr_q <= cfr_pkg::ATTR_RESET;
                end else if (attr_if.wr_en) begin
                    attr_q <= attr_if.wr_val[gi];
                end
            end
            assign attr_if.attr[gi] = attr_q;
        end
    endgenerate
endmodule

// ### verilog/cfr_feature_regs.sv
`timescale 1ns/100ps
// coprocessor feature words at selects 0, 1 and 3
module cfr_feature_regs (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [2:0] sel_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic rvalid_o,
    output logic wr_ack_o,
    output logic sel_err_o,
    output logic ro_touch_o,
    output logic rsvd_wr_o,
    output logic [2:0] high_seg_cache_attr_o,
    output logic [2:0] user_seg_cache_attr_o,
    output logic [2:0] seg0_cache_attr_o
);
    logic rst_meta_q;
    logic rst_n_q;
    logic [31:0] word0;
    logic [31:0] word1;
    logic [31:0] word3;
    logic [31:0] rd_word;
    logic wr_word0;
    logic [31:0] rdata_q;
    logic rvalid_q;
    logic wr_ack_q;
    logic sel_err_q;
    logic ro_touch_q;
    logic rsvd_wr_q;
    logic [2:0] high_q;
    logic [2:0] user_q;
    logic [2:0] seg0_q;

    // word0 bits that software may change: the three cache fields
    localparam logic [31:0] W0_ATTR_MASK =
        (32'h0000_0007 << cfr_pkg::W0_HIGH_LSB) |
        (32'h0000_0007 << cfr_pkg::W0_USER_LSB) |
        (32'h0000_0007 << cfr_pkg::W0_SEG0_LSB);

    cfr_attr_if attr_if ();

    // true when the select names one of the implemented words
    function automatic logic sel_mapped(input logic [2:0] sel);
        sel_mapped = (sel == cfr_pkg::SEL_WORD0) ||
                     (sel == cfr_pkg::SEL_WORD1) ||
                     (sel == cfr_pkg::SEL_WORD3);
    endfunction

    // true when the select names the word holding writable fields
    function automatic logic sel_is_word0(input logic [2:0] sel);
        sel_is_word0 = (sel == cfr_pkg::SEL_WORD0);
    endfunction

    // reset release through two flip-flops
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // attribute storage
    cfr_attr_store u_attr (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .attr_if(attr_if)
    );

    // only a write to word0 loads the fields; other selects change nothing
    assign wr_word0 = wr_i && sel_is_word0(sel_i);
    assign attr_if.wr_en = wr_word0;
    assign attr_if.wr_val[cfr_pkg::ATTR_HIGH] =
        wdata_i[cfr_pkg::W0_HIGH_LSB +: cfr_pkg::ATTR_W];
    assign attr_if.wr_val[cfr_pkg::ATTR_USER] =
        wdata_i[cfr_pkg::W0_USER_LSB +: cfr_pkg::ATTR_W];
    assign attr_if.wr_val[cfr_pkg::ATTR_SEG0] =
        wdata_i[cfr_pkg::W0_SEG0_LSB +: cfr_pkg::ATTR_W];

    // word0: fixed features plus the stored cache fields
    always_comb begin
        word0 = 32'h0000_0000; // reserved bits stay zero
        word0[cfr_pkg::W0_NEXT_BIT] = cfr_pkg::W0_NEXT_VAL;
        word0[cfr_pkg::W0_HIGH_LSB +: cfr_pkg::ATTR_W] =
            attr_if.attr[cfr_pkg::ATTR_HIGH];
        word0[cfr_pkg::W0_USER_LSB +: cfr_pkg::ATTR_W] =
            attr_if.attr[cfr_pkg::ATTR_USER];
        word0[cfr_pkg::W0_CUSTOM_BIT] = cfr_pkg::W0_CUSTOM_VAL;
        word0[cfr_pkg::W0_SIMPLE_BE_BIT] = cfr_pkg::W0_SIMPLE_BE_VAL;
        word0[cfr_pkg::W0_MULDIV_BIT] = cfr_pkg::W0_MULDIV_VAL;
        word0[cfr_pkg::W0_DUAL_SRAM_BIT] = cfr_pkg::W0_DUAL_SRAM_VAL;
        word0[cfr_pkg::W0_BYTE_ORDER_BIT] = cfr_pkg::W0_BYTE_ORDER_VAL;
        word0[cfr_pkg::W0_ARCH_LSB +: 2] = cfr_pkg::W0_ARCH_VAL;
        word0[cfr_pkg::W0_REL_LSB +: 3] = cfr_pkg::W0_REL_VAL;
        word0[cfr_pkg::W0_MAP_LSB +: 3] = cfr_pkg::W0_MAP_VAL;
        word0[cfr_pkg::W0_SEG0_LSB +: cfr_pkg::ATTR_W] =
            attr_if.attr[cfr_pkg::ATTR_SEG0];
    end

    // word1: fixed feature presence bits, the rest zero
    always_comb begin
        word1 = 32'h0000_0000; // unimplemented bits 30-5
        word1[cfr_pkg::W1_NEXT_BIT] = cfr_pkg::W1_NEXT_VAL;
        word1[cfr_pkg::W1_PERF_BIT] = cfr_pkg::W1_PERF_VAL;
        word1[cfr_pkg::W1_DEBUG_BIT] = cfr_pkg::W1_DEBUG_VAL;
        word1[cfr_pkg::W1_WATCH_BIT] = cfr_pkg::W1_WATCH_VAL;
        word1[cfr_pkg::W1_COMPRESSED_BIT] = cfr_pkg::W1_COMPRESSED_VAL;
        word1[cfr_pkg::W1_FLOAT_BIT] = cfr_pkg::W1_FLOAT_VAL;
    end

    // word3: fixed extension and interrupt features, the rest zero
    always_comb begin
        word3 = 32'h0000_0000; // unimplemented bits
        word3[cfr_pkg::W3_RSVD_BIT] = cfr_pkg::W3_RSVD_VAL;
        word3[cfr_pkg::W3_PRIO_LSB +: 2] = cfr_pkg::W3_PRIO_VAL;
        word3[cfr_pkg::W3_CISA_REV_LSB +: 3] = cfr_pkg::W3_CISA_REV_VAL;
        word3[cfr_pkg::W3_ISA_LSB +: 2] = cfr_pkg::W3_ISA_VAL;
        word3[cfr_pkg::W3_EXC_ISA_BIT] = cfr_pkg::W3_EXC_ISA_VAL;
        word3[cfr_pkg::W3_MCU_BIT] = cfr_pkg::W3_MCU_VAL;
        word3[cfr_pkg::W3_USER_LOCAL_REG_FLAG_BIT] = cfr_pkg::W3_USER_LOCAL_REG_FLAG_VAL;
        word3[cfr_pkg::W3_RXI_BIT] = cfr_pkg::W3_RXI_VAL;
        word3[cfr_pkg::W3_EXT_VECTOR_CTRL_FLAG_BIT] = cfr_pkg::W3_EXT_VECTOR_CTRL_FLAG_VAL;
        word3[cfr_pkg::W3_VECTORED_IRQ_FLAG_BIT] = cfr_pkg::W3_VECTORED_IRQ_FLAG_VAL;
        word3[cfr_pkg::W3_DEVICE_MAP_FLAG_BIT] = cfr_pkg::W3_DEVICE_MAP_FLAG_VAL;
        word3[cfr_pkg::W3_SPAGE_BIT] = cfr_pkg::W3_SPAGE_VAL;
        word3[cfr_pkg::W3_FLOW_BIT] = cfr_pkg::W3_FLOW_VAL;
        word3[cfr_pkg::W3_TRACE_BIT] = cfr_pkg::W3_TRACE_VAL;
    end

    // read multiplexer; an unmapped select reads as zero
    always_comb begin
        unique case (sel_i)
            cfr_pkg::SEL_WORD0: rd_word = word0;
            cfr_pkg::SEL_WORD1: rd_word = word1;
            cfr_pkg::SEL_WORD3: rd_word = word3;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // read data and its valid strobe, one cycle after the request
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_i;
            if (rd_i) begin
                rdata_q <= rd_word; // sees the value before a same-cycle write
            end
        end
    end

    // write acknowledge and unmapped select report
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wr_ack_q <= 1'b0;
            sel_err_q <= 1'b0;
        end else begin
            wr_ack_q <= wr_i;
            sel_err_q <= (rd_i || wr_i) && !sel_mapped(sel_i);
        end
    end

    // write that tried to alter a read-only bit; the bit keeps its value
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ro_touch_q <= 1'b0;
        end else if (!wr_i) begin
            ro_touch_q <= 1'b0;
        end else if (sel_is_word0(sel_i)) begin
            ro_touch_q <= ((wdata_i ^ word0) & ~cfr_pkg::W0_RSVD_MASK &
                ~W0_ATTR_MASK) != 32'h0000_0000;
        end else if (sel_i == cfr_pkg::SEL_WORD1) begin
            ro_touch_q <= wdata_i != word1;
        end else if (sel_i == cfr_pkg::SEL_WORD3) begin
            ro_touch_q <= wdata_i != word3;
        end else begin
            ro_touch_q <= 1'b0;
        end
    end

    // software broke the write-zero convention on word0 reserved bits
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rsvd_wr_q <= 1'b0;
        end else begin
            rsvd_wr_q <= wr_word0 &&
                ((wdata_i & cfr_pkg::W0_RSVD_MASK) != 32'h0000_0000);
        end
    end

    // registered copies of the cache fields for the memory system
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            high_q <= cfr_pkg::ATTR_RESET;
            user_q <= cfr_pkg::ATTR_RESET;
            seg0_q <= cfr_pkg::ATTR_RESET;
        end else begin
            high_q <= attr_if.attr[cfr_pkg::ATTR_HIGH];
            user_q <= attr_if.attr[cfr_pkg::ATTR_USER];
            seg0_q <= attr_if.attr[cfr_pkg::ATTR_SEG0];
        end
    end

    // outputs straight from flip-flops
    assign rdata_o = rdata_q;
    assign rvalid_o = rvalid_q;
    assign wr_ack_o = wr_ack_q;
    assign sel_err_o = sel_err_q;
    assign ro_touch_o = ro_touch_q;
    assign rsvd_wr_o = rsvd_wr_q;
    assign high_seg_cache_attr_o = high_q;
    assign user_seg_cache_attr_o = user_q;
    assign seg0_cache_attr_o = seg0_q;
endmodule

// ### tb/cfr_feature_regs_properties.sv
`timescale 1ns/100ps
// watches access timing and fixed contents of the feature words
module cfr_feature_regs_properties (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [2:0] sel_i,
    input wire logic [31:0] wdata_i,
    input wire logic [31:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic wr_ack_o,
    input wire logic sel_err_o,
    input wire logic ro_touch_o,
    input wire logic rsvd_wr_o,
    input wire logic [2:0] high_seg_cache_attr_o,
    input wire logic [2:0] user_seg_cache_attr_o,
    input wire logic [2:0] seg0_cache_attr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // select decode
    logic unmapped;
    logic w0_wr;
    logic [8:0] wr_fields;
    assign unmapped = (sel_i != 3'h0) && (sel_i != 3'h1) && (sel_i != 3'h3);
    assign wr_fields = {wdata_i[30:25], wdata_i[2:0]};
    assign w0_wr = wr_i && (sel_i == 3'h0);

    chk_rd_answer: assert property (rd_i |=> rvalid_o)
        else $error("read not answered next cycle");
    chk_word0_fixed: assert property (rd_i && sel_i == 3'h0 |=>
        (rdata_o & 32'h81ff_fff8) == 32'h8021_0580) else $error("word0 fixed bits wrong");
    chk_word1_value: assert property (rd_i && sel_i == 3'h1 |=>
        rdata_o == 32'h8000_0012) else $error("word1 value wrong");
    chk_word3_value: assert property (rd_i && sel_i == 3'h3 |=>
        rdata_o == 32'h0023_7068) else $error("word3 value wrong");
    chk_attr_follow: assert property (w0_wr |-> ##2
        {high_seg_cache_attr_o, user_seg_cache_attr_o, seg0_cache_attr_o} ==
        $past(wr_fields, 2)) else $error("attr not stored");
    chk_attr_hold: assert property (!w0_wr ##1 !w0_wr |=>
        $stable({high_seg_cache_attr_o, user_seg_cache_attr_o, seg0_cache_attr_o}))
        else $error("attr changed without write");
    chk_rsvd_flag: assert property (w0_wr && |(wdata_i & 32'h018e_0078) |=> rsvd_wr_o)
        else $error("reserved write not flagged");
    chk_unmapped_zero: assert property (rd_i && unmapped |=>
        sel_err_o && rdata_o == 32'h0) else $error("unmapped read not refused");
    chk_rdata_hold: assert property (!rd_i |=> $stable(rdata_o) && !rvalid_o)
        else $error("read data moved without read");
    chk_wr_ack: assert property (wr_i |=> wr_ack_o ##1 !$past(wr_i) || wr_ack_o)
        else $error("write not acknowledged");
endmodule

bind cfr_feature_regs cfr_feature_regs_properties cfr_feature_regs_properties_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .rd_i(rd_i), .wr_i(wr_i), .sel_i(sel_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .wr_ack_o(wr_ack_o),
    .sel_err_o(sel_err_o), .ro_touch_o(ro_touch_o), .rsvd_wr_o(rsvd_wr_o),
    .high_seg_cache_attr_o(high_seg_cache_attr_o),
    .user_seg_cache_attr_o(user_seg_cache_attr_o), .seg0_cache_attr_o(seg0_cache_attr_o));

// ### tb/tb_top.sv
`timescale 1ns/100ps
// drives coprocessor reads and writes and checks the feature words
module tb_top;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic rd_i = 1'b0;
    logic wr_i = 1'b0;
    logic [2:0] sel_i = 3'h0;
    logic [31:0] wdata_i = 32'h0;
    logic [31:0] rdata_o;
    logic rvalid_o, wr_ack_o, sel_err_o, ro_touch_o, rsvd_wr_o;
    logic [2:0] high_o, user_o, seg0_o;
    int n_fail = 0;
    int samples_checked = 0;
    localparam logic [31:0] W0_RST = 32'ha421_0582;
    localparam logic [31:0] W1_VAL = 32'h8000_0012;
    localparam logic [31:0] W3_VAL = 32'h0023_7068;

    // free running clock
    always #5 clk_i = ~clk_i;

    cfr_feature_regs cfr_feature_regs_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .rd_i(rd_i), .wr_i(wr_i), .sel_i(sel_i),
        .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .wr_ack_o(wr_ack_o),
        .sel_err_o(sel_err_o), .ro_touch_o(ro_touch_o), .rsvd_wr_o(rsvd_wr_o),
        .high_seg_cache_attr_o(high_o), .user_seg_cache_attr_o(user_o),
        .seg0_cache_attr_o(seg0_o));

    // compares one value and counts
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one read; the answer lands one cycle after the request is taken
    task automatic rd(input logic [2:0] s, input logic [31:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        sel_i <= s;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rvalid", 32'h1, {31'h0, rvalid_o});
        chk("rdata", exp, rdata_o);
        chk("sel_err", {31'h0, s == 3'h2 || s > 3'h3}, {31'h0, sel_err_o});
    endtask

    // one write; flags are {ro_touch, rsvd_wr, sel_err}
    task automatic wr(input logic [2:0] s, input logic [31:0] d, input logic [2:0] flags);
        @(posedge clk_i);
        wr_i <= 1'b1;
        sel_i <= s;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        #1;
        chk("wr_ack", 32'h1, {31'h0, wr_ack_o});
        chk("wr_flags", {29'h0, flags}, {29'h0, ro_touch_o, rsvd_wr_o, sel_err_o});
    endtask

    // attr outputs, high then user then seg0
    task automatic chk_attr(input logic [8:0] exp);
        chk("attr", {23'h0, exp}, {23'h0, high_o, user_o, seg0_o});
    endtask

    // prints counts and verdict, ends the run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk_attr(9'h092);
        rd(3'h0, W0_RST);
        rd(3'h1, W1_VAL);
        rd(3'h3, W3_VAL);
        for (int s = 2; s < 8; s++) begin
            if (s != 3) begin
                rd(s[2:0], 32'h0);
                wr(s[2:0], 32'hffff_ffff, 3'h1);
            end
        end
        wr(3'h0, 32'hffff_ffff, 3'h6);
        @(posedge clk_i);
        #1;
        chk_attr(9'h1ff);
        rd(3'h0, 32'hfe21_0587);
        wr(3'h0, 32'hba21_0581, 3'h0);
        @(posedge clk_i);
        #1;
        chk_attr(9'h0e9);
        rd(3'h0, 32'hba21_0581);
        wr(3'h1, 32'h0, 3'h4);
        wr(3'h3, 32'hffff_ffff, 3'h4);
        rd(3'h1, W1_VAL);
        rd(3'h3, W3_VAL);
        // read and write together: the read sees the old word
        @(posedge clk_i);
        rd_i <= 1'b1;
        wr_i <= 1'b1;
        sel_i <= 3'h0;
        wdata_i <= W0_RST;
        @(posedge clk_i);
        rd_i <= 1'b1;
        wr_i <= 1'b0;
        sel_i <= 3'h1;
        #1;
        chk("rdata_old", 32'hba21_0581, rdata_o);
        @(posedge clk_i);
        sel_i <= 3'h0;
        #1;
        chk("rdata_b2b", W1_VAL, rdata_o);
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk("rdata_new", W0_RST, rdata_o);
        // reset in mid run restores the cache fields
        wr(3'h0, 32'h8021_0580, 3'h0);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk_attr(9'h092);
        @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(3'h0, W0_RST);
        end_sim;
    end

    // cuts a hang short
    initial begin
        #100000;
        n_fail++;
        end_sim;
    end
endmodule
